// ### encoder_params.svh
// Offsets, reset values and timing counts of the encoder counter block.
// Assumes a 100 MHz module clock and a 32-bit AHB-Lite register bus.
`ifndef ENCODER_PARAMS_SVH
`define ENCODER_PARAMS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define CFG_BASE    12'h000
`define LATCH_BASE  12'h020
`define CTRL_OFS    12'h040
`define STAT_OFS    12'h044
`define SP_BASE     12'h400
`define SP_SPAN     12'h200

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_NS      10
`define TICK_NS     200
`define TICK_CYC    ((`TICK_NS + `CLK_NS - 1) / `CLK_NS)
`define SP_PER_CH   16

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define CTRL_RUN_BIT 0
`define STAT_IDX_LSB 8
`define STAT_RUN_BIT 16
`define CFG_RST_LOW  20'h00000

`endif

// ### enc_pkg.sv
// Types of the encoder counter block: modes, carriers, register layouts.
// Assumes encoder_params.svh supplies the numeric constants.
`default_nettype none
package enc_pkg;

    // Channel counting modes
    typedef enum logic [1:0] {
        MODE_TOTAL  = 2'h0,
        MODE_ENC    = 2'h1,
        MODE_PERIOD = 2'h2,
        MODE_WIDTH  = 2'h3
    } mode_t;

    // Encoder edge multiplier
    typedef enum logic [1:0] {
        OPT_1X = 2'h0,
        OPT_2X = 2'h1,
        OPT_4X = 2'h2
    } enc_opt_t;

    // Setpoint comparison kinds
    typedef enum logic [1:0] {
        SP_OFF = 2'h0,
        SP_GT  = 2'h1,
        SP_LT  = 2'h2,
        SP_EQ  = 2'h3
    } sp_kind_t;

    // Per-channel configuration word
    typedef struct packed {
        logic [11:0] tick;
        logic [7:0]  deb_len;
        logic [3:0]  map_sel;
        logic        dout_en;
        logic        src_map;
        logic        clr_en;
        logic        gate_en;
        logic [1:0]  opt;
        mode_t       mode;
    } cfg_t;

    // One setpoint entry
    typedef struct packed {
        sp_kind_t    kind;
        logic [15:0] limit;
    } sp_t;

    // Host channel select during a scan
    typedef struct packed {
        logic       valid;
        logic [2:0] chan;
    } scan_req_t;

    // Latched value returned to the host
    typedef struct packed {
        logic        valid;
        logic        marker;
        logic [15:0] data;
    } scan_resp_t;

    // Register bus slave phase
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_DATA = 2'b10
    } bus_st_t;

endpackage
`default_nettype wire

// ### encoder_scan_counter.sv
// Eight-channel encoder and event counter with scan latch and setpoints.
// Assumes AHB-Lite master on one clock; inputs synchronous-safe via sync.
//
// What this block does
// R1: Encoder phase A goes on an odd channel, phase B on the next even.
// R2: Every channel counter is captured into a holding register each scan.
// R3: Scan start latches all counts; selected channel's latch goes to host.
// R4: Acquisition start clears counters; first scan returns zero.
// R5: Each of the eight channels owns exactly one detection flag.
// R6: Any detection flag can be counted by an otherwise unused channel.
// R7: Each channel checks up to 16 setpoints against every scan sample.
// R8: All 16 setpoints of a channel are stepped within one microsecond.
// R9: Search for a sample stops at the first matching setpoint.
// R10: A match raises the flag; digital output updates only if enabled.
// R11: Flag is high exactly for matching samples, low for others.
// R12: Setpoints compare latched scan data only, never the live counter.
// R13: A flag can clock another counter or have its pulse width measured.
// R14: Totalize mode counts index pulses, 16-bit, saturating at the top.
// R15: Encoder mode counts 4X into 16 bits; mapped channel may clear it.
// R16: Period mode times the channel's own input rising edges in ticks, ungated, tick selectable.
// R17: Index-referenced position is valid only after the first index pulse.
// R18: Matches serve as data markers, output updates and mapped sources.
// R19: Each channel input has its own debounce time.
// R20: Encoder direction from A and the next even channel B: A leading B counts up, B leading A counts down.
// R21: Mapped clear resets the counter on each mapped rising edge, except in period mode.
// R22: In totalize and encoder modes, mapped gate counts only while mapped is high, holds while low.
// R23: Count mode picks 1X, 2X or 4X edges.
// R24: All channel inputs are synchronised before edge detection.
//
// Added by the designer: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "encoder_params.svh"

module encoder_scan_counter
(
    input  wire logic              clock,
    input  wire logic              rst_n,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output var  logic [31:0]       hrdata,
    output var  logic              hreadyout,
    output var  logic              hresp,
    input  wire logic [7:0]        chan_in,
    input  wire logic              scan_begin_pulse,
    input  wire enc_pkg::scan_req_t  scan_req,
    output var  enc_pkg::scan_resp_t scan_resp,
    output var  logic [7:0]        setpoint_hit,
    output var  logic [7:0]        dig_out,
    output var  logic [7:0]        index_seen
);
    import enc_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        bus_st_t                bus_st;
        logic                   pend_write;
        logic [11:0]            pend_addr;
        logic                   hreadyout;
        logic                   hresp;
        logic [31:0]            hrdata;
        logic [7:0][31:0]       cfg;
        logic                   run;
        logic                   first_pend;
        logic [127:0][17:0]     sp;
        logic [7:0]             sync1;
        logic [7:0]             sync2;
        logic [7:0]             deb;
        logic [7:0]             deb_prev;
        logic [7:0][7:0]        deb_cnt;
        logic [7:0]             map_prev;
        logic [7:0][15:0]       cnt;
        logic [7:0][15:0]       aux;
        logic [7:0][11:0]       presc;
        logic [7:0][15:0]       latch;
        logic [7:0]             idx_seen;
        logic                   srch_on;
        logic [3:0]             srch_idx;
        logic [7:0]             srch_done;
        logic [7:0]             srch_hit;
        logic [7:0]             det;
        logic [7:0]             dout;
        scan_resp_t             scan;
    } state_t;

    // Reset image: idle bus, default tick, everything else clear
    function automatic state_t reset_state();
        state_t r;
        r = '0;
        r.bus_st = BUS_IDLE;
        r.hreadyout = 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            r.cfg[i] = {12'(`TICK_CYC), `CFG_RST_LOW};
        end
        return r;
    endfunction

    localparam state_t ST_RST = reset_state();

    // Mapped source: 0-7 channel inputs, 8-15 detection flags
    function automatic logic map_pick(input logic [3:0] sel,
                                      input logic [7:0] deb,
                                      input logic [7:0] det);
        return sel[3] ? det[sel[2:0]] : deb[sel[2:0]];
    endfunction

    // Setpoint comparison against one latched sample
    function automatic logic sp_match(input logic [17:0] w,
                                      input logic [15:0] v);
        sp_t e;
        e = sp_t'(w);
        unique case (e.kind)
            SP_GT:   return v > e.limit;
            SP_LT:   return v < e.limit;
            SP_EQ:   return v == e.limit;
            SP_OFF:  return 1'b0;
        endcase
    endfunction

    // Saturating 16-bit increment
    function automatic logic [15:0] sat_inc(input logic [15:0] v);
        return (v == 16'hFFFF) ? v : v + 16'h0001;
    endfunction

    state_t q;
    state_t s;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        cfg_t        c;
        logic        src;
        logic        srcp;
        logic        rise;
        logic        fall;
        logic        gate_ok;
        logic        mcur;
        logic        a_ed;
        logic        b_ed;
        logic        up;
        logic        step;
        logic        tk;
        logic        accept;
        logic [11:0] a;
        logic [7:0]  hit_n;
        logic [7:0]  done_n;
        c = '0;
        src = 1'b0;
        srcp = 1'b0;
        rise = 1'b0;
        fall = 1'b0;
        gate_ok = 1'b0;
        mcur = 1'b0;
        a_ed = 1'b0;
        b_ed = 1'b0;
        up = 1'b0;
        step = 1'b0;
        tk = 1'b0;
        a = q.pend_addr;
        hit_n = q.srch_hit;
        done_n = q.srch_done;
        s = q;
        accept = hsel & htrans[1] & hready;

        // Input synchroniser and per-channel debounce
        s.sync1 = chan_in; // R24
        s.sync2 = q.sync1; // R24
        s.deb_prev = q.deb;
        for (int ch = 0; ch < 8; ch++)
        begin
            c = cfg_t'(q.cfg[ch]);
            if (q.sync2[ch] == q.deb[ch])
                s.deb_cnt[ch] = 8'h00;
            else if (q.deb_cnt[ch] >= c.deb_len) // R19
            begin
                s.deb[ch] = q.sync2[ch];
                s.deb_cnt[ch] = 8'h00;
            end
            else
                s.deb_cnt[ch] = q.deb_cnt[ch] + 8'h01;
        end

        // Channel counters
        for (int ch = 0; ch < 8; ch++)
        begin
            c = cfg_t'(q.cfg[ch]);
            mcur = map_pick(c.map_sel, q.deb, q.det); // R6 R13 R18
            s.map_prev[ch] = mcur;
            src = c.src_map ? mcur : q.deb[ch];
            srcp = c.src_map ? q.map_prev[ch] : q.deb_prev[ch];
            rise = src & ~srcp;
            fall = ~src & srcp;
            gate_ok = ~c.gate_en | mcur; // R22
            tk = (q.presc[ch] + 12'h001 >= c.tick);
            s.presc[ch] = tk ? 12'h000 : q.presc[ch] + 12'h001;
            a_ed = q.deb[ch] ^ q.deb_prev[ch];
            b_ed = q.deb[ch | 1] ^ q.deb_prev[ch | 1];
            up = q.deb[ch] ^ q.deb_prev[ch | 1]; // R20
            unique case (c.opt)
                OPT_1X:  step = a_ed & q.deb[ch]; // R23
                OPT_2X:  step = a_ed; // R23
                OPT_4X:  step = a_ed | b_ed; // R15 R23
                default: step = 1'b0;
            endcase
            if (q.run && !q.first_pend)
            begin
                unique case (c.mode)
                    MODE_TOTAL:
                        if (rise && gate_ok)
                            s.cnt[ch] = sat_inc(q.cnt[ch]); // R14
                    MODE_ENC:
                        if (ch % 2 == 0 && step && gate_ok)
                            s.cnt[ch] = up ? q.cnt[ch] + 16'h0001
                                           : q.cnt[ch] - 16'h0001; // R15
                    MODE_PERIOD:
                        if (q.deb[ch] && !q.deb_prev[ch])
                        begin
                            s.cnt[ch] = q.aux[ch]; // R16
                            s.aux[ch] = 16'h0000;
                        end
                        else if (tk)
                            s.aux[ch] = sat_inc(q.aux[ch]); // R16
                    MODE_WIDTH:
                        if (rise)
                            s.aux[ch] = 16'h0000;
                        else if (fall)
                            s.cnt[ch] = q.aux[ch]; // R13
                        else if (src && tk)
                            s.aux[ch] = sat_inc(q.aux[ch]);
                endcase
                if (c.clr_en && mcur && !q.map_prev[ch]
                    && c.mode != MODE_PERIOD)
                begin
                    s.cnt[ch] = 16'h0000; // R21
                    s.idx_seen[ch] = 1'b1; // R17
                end
            end
        end

        // Setpoint search over latched samples, one entry per cycle
        if (q.srch_on)
        begin
            for (int ch = 0; ch < 8; ch++)
            begin
                if (!q.srch_done[ch]
                    && sp_match(q.sp[{3'(ch), q.srch_idx}], q.latch[ch]))
                begin
                    hit_n[ch] = 1'b1; // R7 R12
                    done_n[ch] = 1'b1; // R9
                end
            end
            s.srch_hit = hit_n;
            s.srch_done = done_n;
            s.srch_idx = q.srch_idx + 4'h1; // R8
            if (q.srch_idx == 4'(`SP_PER_CH - 1))
            begin
                s.srch_on = 1'b0;
                s.det = hit_n; // R5 R10 R11
                for (int ch = 0; ch < 8; ch++)
                begin
                    c = cfg_t'(q.cfg[ch]);
                    if (c.dout_en)
                        s.dout[ch] = hit_n[ch]; // R10
                end
            end
        end

        // Scan start: latch all counters and restart the search
        if (q.run && scan_begin_pulse)
        begin
            s.srch_on = 1'b1;
            s.srch_idx = 4'h0;
            s.srch_done = 8'h00;
            s.srch_hit = 8'h00;
            if (q.first_pend)
            begin
                s.latch = '0; // R4
                s.first_pend = 1'b0;
            end
            else
                s.latch = q.cnt; // R2 R3
        end

        // Host reads the latched value of the selected channel
        s.scan.valid = scan_req.valid;
        if (scan_req.valid)
        begin
            s.scan.data = q.latch[scan_req.chan]; // R3
            s.scan.marker = q.det[scan_req.chan]; // R18
        end

        // Register bus: one wait state per transfer
        s.hresp = 1'b0;
        unique case (q.bus_st)
            BUS_IDLE:
                if (accept)
                begin
                    s.bus_st = BUS_DATA;
                    s.hreadyout = 1'b0;
                    s.pend_addr = haddr[11:0];
                    s.pend_write = hwrite;
                end
            BUS_DATA:
            begin
                s.bus_st = BUS_IDLE;
                s.hreadyout = 1'b1;
                s.hrdata = 32'h0000_0000;
                if (a < `LATCH_BASE)
                begin
                    if (q.pend_write)
                        s.cfg[a[4:2]] = hwdata;
                    else
                        s.hrdata = q.cfg[a[4:2]];
                end
                else if (a < `CTRL_OFS)
                begin
                    if (!q.pend_write)
                        s.hrdata = {16'h0000, q.latch[a[4:2]]};
                end
                else if (a == `CTRL_OFS)
                begin
                    if (q.pend_write)
                    begin
                        s.run = hwdata[`CTRL_RUN_BIT];
                        if (hwdata[`CTRL_RUN_BIT] && !q.run)
                        begin
                            s.first_pend = 1'b1;
                            s.cnt = '0; // R4
                            s.aux = '0;
                            s.latch = '0;
                            s.idx_seen = 8'h00;
                            s.det = 8'h00;
                            s.srch_on = 1'b0;
                        end
                    end
                    else
                        s.hrdata = {31'h0, q.run};
                end
                else if (a == `STAT_OFS)
                begin
                    if (!q.pend_write)
                        s.hrdata = {15'h0, q.run, q.idx_seen, q.det};
                end
                else if (a >= `SP_BASE && a < `SP_BASE + `SP_SPAN)
                begin
                    if (q.pend_write)
                        s.sp[a[8:2]] = hwdata[17:0];
                    else
                        s.hrdata = {14'h0, q.sp[a[8:2]]};
                end
            end
            default:
                s.bus_st = BUS_IDLE;
        endcase
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            q <= ST_RST;
        else
            q <= s;
    end

    // Outputs straight from state
    assign hrdata = q.hrdata;
    assign hreadyout = q.hreadyout;
    assign hresp = q.hresp;
    assign scan_resp = q.scan;
    assign setpoint_hit = q.det;
    assign dig_out = q.dout;
    assign index_seen = q.idx_seen;

endmodule
`default_nettype wire

// ### scan_counter_sva.sv
// Bus and scan-link timing checks for encoder_scan_counter.
// Assumes it is bound onto the top module and sees its ports only.
`timescale 1ns/10ps
`default_nettype none
module scan_counter_sva
(
    input wire logic                clock,
    input wire logic                rst_n,
    input wire logic                hsel,
    input wire logic [1:0]          htrans,
    input wire logic                hready,
    input wire logic [31:0]         hrdata,
    input wire logic                hreadyout,
    input wire logic                hresp,
    input wire logic                scan_begin_pulse,
    input wire enc_pkg::scan_req_t  scan_req,
    input wire enc_pkg::scan_resp_t scan_resp,
    input wire logic [7:0]          setpoint_hit,
    input wire logic [7:0]          dig_out
);
    import enc_pkg::*;
    // ------------------------------
    // Assertions
    // ------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    property p_okay; hresp == 1'b0; endproperty
    a_okay: assert property (p_okay) else $error("hresp not okay");
    property p_wait;
        hsel && htrans[1] && hready && hreadyout |=> !hreadyout ##1 hreadyout;
    endproperty
    a_wait: assert property (p_wait) else $error("wait state wrong");
    property p_one_wait; !hreadyout |=> hreadyout; endproperty
    a_one_wait: assert property (p_one_wait) else $error("wait too long");
    property p_rdata;
        $changed(hrdata) |-> hreadyout && !$past(hreadyout);
    endproperty
    a_rdata: assert property (p_rdata) else $error("hrdata moved early");
    property p_resp_valid;
        scan_resp.valid == $past(scan_req.valid);
    endproperty
    a_resp_valid: assert property (p_resp_valid)
        else $error("scan_resp valid late");
    property p_resp_hold;
        !scan_resp.valid |-> $stable(scan_resp.data)
            && $stable(scan_resp.marker);
    endproperty
    a_resp_hold: assert property (p_resp_hold)
        else $error("scan_resp not held");
    property p_marker;
        scan_resp.valid |->
            scan_resp.marker == $past(setpoint_hit[scan_req.chan]);
    endproperty
    a_marker: assert property (p_marker)
        else $error("marker mismatch");
    property p_flag_time;
        $changed(setpoint_hit) |-> $past(scan_begin_pulse, 17);
    endproperty
    a_flag_time: assert property (p_flag_time)
        else $error("flag changed off search end");
    property p_dout_time; $changed(dig_out) |-> $past(scan_begin_pulse, 17);
    endproperty
    a_dout_time: assert property (p_dout_time)
        else $error("dig_out changed off search end");
endmodule
bind encoder_scan_counter scan_counter_sva u_sva
(
    .clock(clock), .rst_n(rst_n), .hsel(hsel), .htrans(htrans),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .scan_begin_pulse(scan_begin_pulse),
    .scan_req(scan_req), .scan_resp(scan_resp),
    .setpoint_hit(setpoint_hit), .dig_out(dig_out)
);
`default_nettype wire

// ### quad_encoder_model.sv
// Quadrature encoder model: phases A and B moved by step requests.
// Assumes steps are spaced wider than the block's input synchroniser.
`timescale 1ns/10ps
`default_nettype none
module quad_encoder_model
(
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic step,
    input  wire logic dir,
    output var  logic phase_a,
    output var  logic phase_b
);
    logic [1:0] pos_reg;
    // Quarter-cycle position, forward makes A lead B
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            pos_reg <= 2'h0;
        else if (step)
            pos_reg <= dir ? pos_reg - 2'h1 : pos_reg + 2'h1;
    end
    // Gray phases: A to an odd channel, B to the next even one
    assign phase_a = ^pos_reg;
    assign phase_b = pos_reg[1];
endmodule
`default_nettype wire

// ### encoder_counter_scan_latch_detect_tb.sv
// Self-checking bench for encoder_scan_counter with an encoder model.
// Assumes enc_pkg, encoder_params.svh and quad_encoder_model compiled.
`timescale 1ns/10ps
`default_nettype none
`include "encoder_params.svh"
module encoder_counter_scan_latch_detect_tb;
    import enc_pkg::*;
    logic        clock, hreadyout, hresp, enc_a, enc_b;
    logic        rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic        scan_begin_pulse = 1'b0, step = 1'b0, dir = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [7:0]  aux = 8'h00, setpoint_hit, dig_out, index_seen;
    scan_req_t   scan_req = '0;
    scan_resp_t  scan_resp;
    int          fail_count = 0, comparisons = 0, exp_c, n, m, lim;

    encoder_scan_counter uut
    (
        .clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp),
        .chan_in({aux[7:2], enc_b, enc_a}),
        .scan_begin_pulse(scan_begin_pulse), .scan_req(scan_req),
        .scan_resp(scan_resp), .setpoint_hit(setpoint_hit),
        .dig_out(dig_out), .index_seen(index_seen)
    );
    quad_encoder_model enc_model
    (
        .clock(clock), .rst_n(rst_n), .step(step), .dir(dir),
        .phase_a(enc_a), .phase_b(enc_b)
    );

    // Clock source
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // ------------------------------
    // Tasks and expectations
    // ------------------------------
    function automatic logic [31:0] cfg(mode_t md, logic [1:0] o,
                                        logic [3:0] fl, logic [3:0] ms);
        return {12'h014, 8'h00, ms, fl, o, md};
    endfunction
    function automatic logic [15:0] enc_exp(int f, int r, int o);
        return 16'((f - r) * (1 << o));
    endfunction
    function automatic logic hit(int c);
        return (c == 8) || (c > lim);
    endfunction
    // One AHB-Lite single transfer, entered just after an edge
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {20'h0, a};
        hwrite <= w;
        @(posedge clock);
        while (hreadyout !== 1'b1) @(posedge clock);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge clock);
        while (hreadyout !== 1'b1) @(posedge clock);
        rd = hrdata;
    endtask
    task automatic check(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Scan start, then wait past the setpoint search
    task automatic scan();
        scan_begin_pulse <= 1'b1;
        @(posedge clock);
        scan_begin_pulse <= 1'b0;
        repeat (20) @(posedge clock);
    endtask
    // Fetch one channel over the scan link and the bus
    task automatic grab(input int ch, input logic [15:0] e);
        scan_req <= '{1'b1, ch[2:0]};
        @(posedge clock);
        scan_req <= '0;
        @(posedge clock);
        check("resp_valid", 32'h1, {31'h0, scan_resp.valid});
        check("scan_resp", {16'h0, e}, {16'h0, scan_resp.data});
        bus(1'b0, `LATCH_BASE + 12'(4 * ch), 32'h0);
        check("latch", {16'h0, e}, rd);
    endtask
    task automatic turn(input int q, input logic d);
        repeat (q)
        begin
            step <= 1'b1;
            dir  <= d;
            @(posedge clock);
            step <= 1'b0;
            repeat (6) @(posedge clock);
        end
    endtask
    task automatic blip(input int b, input int k);
        repeat (k)
        begin
            aux[b] <= 1'b1;
            repeat (6) @(posedge clock);
            aux[b] <= 1'b0;
            repeat (6) @(posedge clock);
        end
    endtask
    task automatic start();
        bus(1'b1, `CTRL_OFS, 32'h0);
        bus(1'b1, `CTRL_OFS, 32'h1);
        scan();
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ------------------------------
    // Tests
    // ------------------------------
    initial
    begin
        void'($urandom(34));
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        bus(1'b0, `CFG_BASE, 32'h0);
        check("cfg_reset", 32'h01400000, rd);
        bus(1'b0, `CTRL_OFS, 32'h0);
        check("ctrl_reset", 32'h0, rd);
        bus(1'b0, 12'h100, 32'h0);
        check("unmapped", 32'h0, rd);
        $display("test reset_values done");
        // Each multiplier, forward then backward, wrap allowed
        for (int o = 0; o < 3; o++)
        begin
            bus(1'b1, `CFG_BASE, cfg(MODE_ENC, o[1:0], 4'h0, 4'h0));
            start();
            grab(0, 16'h0);
            n = $urandom_range(8, 2);
            m = $urandom_range(9, 0);
            turn(4 * n, 1'b0);
            turn(4 * m, 1'b1);
            scan();
            grab(0, enc_exp(n, m, o));
        end
        $display("test encoder_modes done");
        // Index on channel 3 clears channel 1 and is totalized
        bus(1'b1, `CFG_BASE, cfg(MODE_ENC, 2'h2, 4'h2, 4'h2));
        start();
        check("index_seen", 32'h0, {24'h0, index_seen});
        turn(4 * $urandom_range(6, 1), 1'b0);
        blip(2, 1);
        turn(4, 1'b0);
        scan();
        check("index_seen", 32'h1, {24'h0, index_seen});
        grab(0, 16'h4);
        grab(2, 16'h1);
        $display("test index_clear done");
        // Gate on channel 6 holds channel 5
        bus(1'b1, `CFG_BASE + 12'h010, cfg(MODE_TOTAL, 2'h0, 4'h1, 4'h5));
        start();
        n = $urandom_range(5, 1);
        m = $urandom_range(5, 1);
        blip(4, n);
        aux[5] <= 1'b1;
        repeat (6) @(posedge clock);
        blip(4, m);
        aux[5] <= 1'b0;
        scan();
        grab(4, 16'(m));
        $display("test gate done");
        // Setpoints on channel 1, flag counted on channel 4
        lim = $urandom_range(13, 2);
        bus(1'b1, `CFG_BASE, cfg(MODE_ENC, 2'h2, 4'h8, 4'h0));
        bus(1'b1, `CFG_BASE + 12'h00C, cfg(MODE_TOTAL, 2'h0, 4'h4, 4'h8));
        bus(1'b1, `SP_BASE, {14'h0, SP_EQ, 16'h0008});
        bus(1'b1, `SP_BASE + 12'h00C, {14'h0, SP_LT, 16'h0000});
        bus(1'b1, `SP_BASE + 12'h03C, {14'h0, SP_GT, 16'(lim)});
        start();
        exp_c = 0;
        for (int j = 1; j < 5; j++)
        begin
            turn(4, 1'b0);
            scan();
            check("hit", {31'h0, hit(4 * j)},
                  {24'h0, setpoint_hit});
            check("dig_out", {31'h0, hit(4 * j)}, {24'h0, dig_out});
            exp_c += int'(hit(4 * j) && !hit(4 * j - 4));
        end
        scan();
        grab(3, 16'(exp_c));
        $display("test setpoints done");
        end_of_test();
    end

    // Watchdog for hangs
    initial
    begin
        repeat (30000) @(posedge clock);
        fail_count++;
        end_of_test();
    end
endmodule
`default_nettype wire
